// ### rtl/hsc_top.sv
// high-speed system clock controller with apb register access
// assumes apb master on MCLK and synchronous pin inputs
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module hsc_top (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // stop mode
  input wire logic STOP_RELEASE,
  output logic STOP_MODE,
  // pins
  output hsc_pkg::hsc_pin_mode_t PIN_MODE,
  output logic OSC_ENABLE,
  output logic OSC_HIGH_GAIN,
  output logic EXT_INPUT_EN,
  // clock routing
  output hsc_pkg::hsc_clk_route_t CLK_ROUTE
);
  import hsc_pkg::*;

  // ************************************************
  // register state
  // ************************************************
  logic gain_ff;
  logic gain_locked_ff;
  logic ext_sel_ff;
  logic osc_sel_ff;
  logic halt_ff;
  logic src_sel_ff;
  logic mode_ff;
  logic mode_stat_ff;
  logic css_ff;
  logic [2:0] div_ff;
  logic [2:0] stab_sel_ff;
  logic stop_ff;
  logic [7:0] gain_cnt_ff;
  logic cpu_hold_ff;
  logic [3:0] pre_ff;
  logic [31:0] rdata_ff;
  logic err_ff;
  logic [4:0] stab_stat;

  logic wr;
  logic rd;
  logic hit;
  logic osc_run;
  logic [31:0] nxt_rdata;
  logic wr_osc;
  logic wr_mosc;
  logic wr_mode;
  logic wr_proc;
  logic wr_ssel;
  logic wr_stop;
  logic gain_change;
  logic gain_rise;

  // ************************************************
  // apb decode
  // ************************************************
  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && PENABLE && !PWRITE;
  assign PREADY = 1'b1;

  always_comb begin
    hit = 1'b1;
    case (PADDR)
      OFS_OSC_CTRL, OFS_MOSC_CTRL, OFS_MCLK_MODE, OFS_PROC_CTRL,
      OFS_STAB_STAT, OFS_STAB_SEL, OFS_STOP_CMD: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // ************************************************
  // write strobes
  // ************************************************
  // one write strobe per writable register, taken in the access cycle
  assign wr_osc = wr && PADDR == OFS_OSC_CTRL;
  assign wr_mosc = wr && PADDR == OFS_MOSC_CTRL;
  assign wr_mode = wr && PADDR == OFS_MCLK_MODE;
  assign wr_proc = wr && PADDR == OFS_PROC_CTRL;
  assign wr_ssel = wr && PADDR == OFS_STAB_SEL;
  assign wr_stop = wr && PADDR == OFS_STOP_CMD;

  // gain write that may still change the bit
  assign gain_change = wr_osc && !gain_locked_ff &&
                       PWDATA[BIT_GAIN] != gain_ff;
  assign gain_rise = gain_change && PWDATA[BIT_GAIN];

  // ************************************************
  // oscillator control
  // ************************************************
  // gain bit accepts one change per reset
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      gain_ff <= 1'b0;
    end else if (gain_change) begin
      gain_ff <= PWDATA[BIT_GAIN];
    end
  end

  // lock keeps later writes from retuning a running oscillator
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      gain_locked_ff <= 1'b0;
    end else if (gain_change) begin
      gain_locked_ff <= 1'b1;
    end
  end

  // external input select, cleared for resonator mode
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ext_sel_ff <= 1'b0;
    end else if (wr_osc) begin
      ext_sel_ff <= PWDATA[BIT_EXTSEL];
    end
  end

  // oscillation select, cleared for port mode
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      osc_sel_ff <= 1'b0;
    end else if (wr_osc) begin
      osc_sel_ff <= PWDATA[BIT_OSCILLATION_PIN_SELECT];
    end
  end

  // halt bit, set at reset and written by software only
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      halt_ff <= RST_HALT;
    end else if (wr_mosc) begin
      halt_ff <= PWDATA[BIT_HALT];
    end
  end

  // stop mode entered by command, left by release input
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      stop_ff <= 1'b0;
    end else if (wr_stop && PWDATA[BIT_STOP]) begin
      stop_ff <= 1'b1;
    end else if (STOP_RELEASE) begin
      stop_ff <= 1'b0;
    end
  end

  assign osc_run = osc_sel_ff && !halt_ff && !stop_ff;

  // pin mode decode
  always_comb begin
    PIN_MODE = PIN_PORT;
    if (osc_sel_ff && !ext_sel_ff) begin
      PIN_MODE = PIN_RESON;
    end else if (osc_sel_ff && ext_sel_ff) begin
      PIN_MODE = PIN_EXTCLK;
    end
  end

  assign OSC_ENABLE = osc_run && !ext_sel_ff;
  assign EXT_INPUT_EN = osc_run && ext_sel_ff;
  assign OSC_HIGH_GAIN = gain_ff;

  // stabilization counter for polling
  hsc_stab_cnt u_stab (
    .MCLK(MCLK),
    .RST_N(RST_N),
    .run(OSC_ENABLE),
    .stat(stab_stat)
  );

  // ************************************************
  // clock selection
  // ************************************************
  // high-speed source select bit
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      src_sel_ff <= 1'b0;
    end else if (wr_mode) begin
      src_sel_ff <= PWDATA[BIT_XSRC];
    end
  end

  // main clock mode bit
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_ff <= 1'b0;
    end else if (wr_mode) begin
      mode_ff <= PWDATA[BIT_MODE];
    end
  end

  // main clock status follows the applied mode
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_stat_ff <= 1'b0;
    end else begin
      mode_stat_ff <= src_sel_ff && mode_ff;
    end
  end

  // cpu source select
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      css_ff <= 1'b0;
    end else if (wr_proc) begin
      css_ff <= PWDATA[BIT_CSS];
    end
  end

  // cpu divider, prohibited codes leave the old ratio
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      div_ff <= RST_DIV;
    end else if (wr_proc) begin
      if (PWDATA[BIT_DIV_LO+2:BIT_DIV_LO] <= 3'h4) begin
        div_ff <= PWDATA[BIT_DIV_LO+2:BIT_DIV_LO];
      end
    end
  end

  // stabilization time select
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      stab_sel_ff <= RST_STAB_SEL;
    end else if (wr_ssel) begin
      stab_sel_ff <= PWDATA[2:0];
    end
  end

  // ************************************************
  // cpu hold after gain set
  // ************************************************
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      gain_cnt_ff <= 8'h00;
      cpu_hold_ff <= 1'b0;
    end else if (gain_rise) begin
      gain_cnt_ff <= 8'(GAIN_HALT_CYC);
      cpu_hold_ff <= 1'b1;
    end else if (gain_cnt_ff != 8'h00) begin
      gain_cnt_ff <= gain_cnt_ff - 8'h01;
      cpu_hold_ff <= gain_cnt_ff != 8'h01;
    end
  end

  // prescaler for cpu divide enables
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pre_ff <= 4'h0;
    end else begin
      pre_ff <= pre_ff + 4'h1;
    end
  end

  // ************************************************
  // routing
  // ************************************************
  always_comb begin
    CLK_ROUTE.main_hs = mode_stat_ff;
    CLK_ROUTE.periph_hs = mode_stat_ff;
    CLK_ROUTE.cpu_en = !cpu_hold_ff && !stop_ff && !css_ff;
    CLK_ROUTE.cpu_div_en = 5'h00;
    case (div_ff)
      3'h0: CLK_ROUTE.cpu_div_en = 5'h01;
      3'h1: CLK_ROUTE.cpu_div_en = {4'h0, pre_ff[0]} << 1;
      3'h2: CLK_ROUTE.cpu_div_en = {4'h0, &pre_ff[1:0]} << 2;
      3'h3: CLK_ROUTE.cpu_div_en = {4'h0, &pre_ff[2:0]} << 3;
      3'h4: CLK_ROUTE.cpu_div_en = {4'h0, &pre_ff} << 4;
      default: CLK_ROUTE.cpu_div_en = 5'h00;
    endcase
  end

  assign STOP_MODE = stop_ff;

  // ************************************************
  // read mux
  // ************************************************
  always_comb begin
    nxt_rdata = 32'h00000000;
    case (PADDR)
      OFS_OSC_CTRL: begin
        nxt_rdata[BIT_GAIN] = gain_ff;
        nxt_rdata[BIT_OSCILLATION_PIN_SELECT] = osc_sel_ff;
        nxt_rdata[BIT_EXTSEL] = ext_sel_ff;
      end
      OFS_MOSC_CTRL: nxt_rdata[BIT_HALT] = halt_ff;
      OFS_MCLK_MODE: begin
        nxt_rdata[BIT_MODE] = mode_ff;
        nxt_rdata[BIT_MSTAT] = mode_stat_ff;
        nxt_rdata[BIT_XSRC] = src_sel_ff;
      end
      OFS_PROC_CTRL: begin
        nxt_rdata[BIT_DIV_LO+2:BIT_DIV_LO] = div_ff;
        nxt_rdata[BIT_CSS] = css_ff;
        nxt_rdata[BIT_CLS] = css_ff;
      end
      OFS_STAB_STAT: nxt_rdata[4:0] = stab_stat;
      OFS_STAB_SEL: nxt_rdata[2:0] = stab_sel_ff;
      default: nxt_rdata = 32'h00000000;
    endcase
  end

  // read data registered at setup, shown in the access cycle
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_ff <= 32'h00000000;
    end else if (PSEL && !PENABLE) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // unmapped address flagged at setup
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      err_ff <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      err_ff <= !hit;
    end
  end

  assign PRDATA = rd ? rdata_ff : 32'h00000000;
  assign PSLVERR = PSEL && PENABLE && err_ff;
endmodule

// ### common/hsc_pkg.sv
// package for the high-speed system clock controller
// assumes apb slave with 32-bit data and word-aligned registers
package hsc_pkg;

  // ************************************************
  // register offsets (byte addresses)
  // ************************************************
  localparam logic [7:0] OFS_OSC_CTRL = 8'h00; // oscillator_control_reg
  localparam logic [7:0] OFS_MOSC_CTRL = 8'h04; // main_osc_control_reg
  localparam logic [7:0] OFS_MCLK_MODE = 8'h08; // main_clock_mode_reg
  localparam logic [7:0] OFS_PROC_CTRL = 8'h0C; // processor_clock_control_reg
  localparam logic [7:0] OFS_STAB_STAT = 8'h10; // stabilization status
  localparam logic [7:0] OFS_STAB_SEL = 8'h14; // stabilization time select
  localparam logic [7:0] OFS_STOP_CMD = 8'h18; // stop instruction strobe

  // ************************************************
  // field positions
  // ************************************************
  localparam int BIT_GAIN = 0;
  localparam int BIT_OSCILLATION_PIN_SELECT = 4;
  localparam int BIT_EXTSEL = 7;
  localparam int BIT_HALT = 7;
  localparam int BIT_MODE = 0;
  localparam int BIT_MSTAT = 1;
  localparam int BIT_XSRC = 2;
  localparam int BIT_DIV_LO = 0;
  localparam int BIT_CSS = 4;
  localparam int BIT_CLS = 5;
  localparam int BIT_STOP = 0;

  // ************************************************
  // reset values
  // ************************************************
  localparam logic [2:0] RST_DIV = 3'h1;
  localparam logic RST_HALT = 1'b1;
  localparam logic [2:0] RST_STAB_SEL = 3'h5;

  // ************************************************
  // timing
  // ************************************************
  localparam int CLK_MHZ = 25;
  localparam int GAIN_HALT_NS = 5000;
  localparam int GAIN_HALT_CYC = (GAIN_HALT_NS * CLK_MHZ + 999) / 1000;
  localparam int STAB_BASE_CYC = 256;

  // ************************************************
  // types
  // ************************************************
  typedef enum logic [1:0] {
    PIN_PORT = 2'b00,
    PIN_RESON = 2'b01,
    PIN_EXTCLK = 2'b10
  } hsc_pin_mode_t;

  typedef struct packed {
    logic main_hs;
    logic periph_hs;
    logic cpu_en;
    logic [4:0] cpu_div_en;
  } hsc_clk_route_t;

endpackage

// ### rtl/hsc_stab_cnt.sv
// oscillation stabilization counter
// assumes run drops whenever the oscillator is halted
`timescale 1ns/100ps
module hsc_stab_cnt (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // control
  input wire logic run,
  // status
  output logic [4:0] stat
);
  import hsc_pkg::*;

  logic [12:0] cnt_ff;
  logic [12:0] nxt_cnt;
  logic [4:0] stat_ff;

  // count while running, saturate at the top
  always_comb begin
    nxt_cnt = cnt_ff;
    if (!run) begin
      nxt_cnt = 13'h0000;
    end else if (cnt_ff != 13'h1FFF) begin
      nxt_cnt = cnt_ff + 13'h0001;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_ff <= 13'h0000;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // one status bit per elapsed stage, thermometer coded
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      stat_ff <= 5'h00;
    end else begin
      stat_ff <= {cnt_ff[12], |cnt_ff[12:11], |cnt_ff[12:10],
                  |cnt_ff[12:9], |cnt_ff[12:8]};
    end
  end

  assign stat = stat_ff;
endmodule

// ### bench/hsc_chk.sv
// port checker for the clock controller
// assumes it is bound into hsc_top
`timescale 1ns/100ps
module hsc_chk (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // outputs watched
  input wire logic STOP_MODE,
  input wire hsc_pkg::hsc_pin_mode_t PIN_MODE,
  input wire logic OSC_ENABLE,
  input wire logic OSC_HIGH_GAIN,
  input wire logic EXT_INPUT_EN,
  input wire hsc_pkg::hsc_clk_route_t CLK_ROUTE
);
  import hsc_pkg::*;
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);
  logic g_ff;
  logic [1:0] n_ff;
  // counts gain changes since reset
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      g_ff <= 1'b0;
      n_ff <= 2'h0;
    end else begin
      g_ff <= OSC_HIGH_GAIN;
      if (g_ff != OSC_HIGH_GAIN && n_ff != 2'h3)
        n_ff <= n_ff + 2'h1;
    end
  end
  chk_gain_once: assert property (n_ff <= 2'h1)
    else $error("gain changed twice");
  chk_gain_hold: assert property
    ($rose(OSC_HIGH_GAIN) |-> ##1 !CLK_ROUTE.cpu_en [*8])
    else $error("cpu clock ran during gain hold");
  chk_reset_port: assert property
    ($rose(RST_N) |-> PIN_MODE == PIN_PORT && !OSC_HIGH_GAIN)
    else $error("pins not port after reset");
  chk_osc_pins: assert property
    (OSC_ENABLE |-> PIN_MODE == PIN_RESON && !EXT_INPUT_EN)
    else $error("oscillator runs outside resonator mode");
  chk_ext_pins: assert property
    (EXT_INPUT_EN |-> PIN_MODE == PIN_EXTCLK)
    else $error("external input outside its mode");
  chk_stop_halt: assert property
    (STOP_MODE |-> !OSC_ENABLE && !EXT_INPUT_EN && !CLK_ROUTE.cpu_en)
    else $error("clock alive in stop mode");
  chk_route_pair: assert property
    (CLK_ROUTE.main_hs == CLK_ROUTE.periph_hs)
    else $error("main and peripheral clocks differ");
  chk_div_pulse: assert property
    (CLK_ROUTE.cpu_div_en[1] |=> !CLK_ROUTE.cpu_div_en[1])
    else $error("divide by two pulse too long");
endmodule

// ### bench/hsc_osc_model.sv
// resonator or external clock source model
// assumes run is high while the device starts it
`timescale 1ns/100ps
module hsc_osc_model (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // control and clock out
  input wire logic run,
  output logic xclk
);
  // toggles while started, stands low otherwise
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N)
      xclk <= 1'b0;
    else if (run)
      xclk <= !xclk;
    else
      xclk <= 1'b0;
  end
endmodule

// ### bench/test_high_speed_sys_clock_ctrl.sv
// bench for the clock controller
// assumes hsc_top as apb slave; the master waits for pready
`timescale 1ns/100ps
module test_high_speed_sys_clock_ctrl;
  import hsc_pkg::*;
  logic mclk, rst_n, psel, penable, pwrite, stp, pready, pslverr, er;
  logic stop_mode, osc_en, gain, ext_en, xclk, x0;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  hsc_pin_mode_t pin;
  hsc_clk_route_t rt;
  int err_count, n_tests, cyc, n, t0, m;

  hsc_top u_hsc_top (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .STOP_RELEASE(stp), .STOP_MODE(stop_mode), .PIN_MODE(pin),
    .OSC_ENABLE(osc_en), .OSC_HIGH_GAIN(gain), .EXT_INPUT_EN(ext_en),
    .CLK_ROUTE(rt));
  hsc_osc_model u_hsc_osc_model (.MCLK(mclk), .RST_N(rst_n),
    .run(osc_en | ext_en), .xclk(xclk));

  // clock and cycle count
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one apb transfer, then one idle cycle
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk("rdata", rd, e);
  endtask

  task t_reset;
    chk("pins", pin, PIN_PORT);
    chk("cpu_en", rt.cpu_en, 1'b1);
    rdc(OFS_MOSC_CTRL, 32'h80);
    rdc(OFS_PROC_CTRL, 32'h1);
    rdc(OFS_STAB_SEL, 32'h5);
  endtask

  task t_gain;
    xfer(1'b1, OFS_OSC_CTRL, 32'h1);
    chk("gain", gain, 1'b1);
    n = 0;
    while (rt.cpu_en !== 1'b1 && n < 300) begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
    chk("hold", n, GAIN_HALT_CYC);
    xfer(1'b1, OFS_OSC_CTRL, 32'h0);
    chk("gain", gain, 1'b1);
  endtask

  task t_reson;
    xfer(1'b1, OFS_OSC_CTRL, 32'h11);
    chk("pins", pin, PIN_RESON);
    xfer(1'b1, OFS_MOSC_CTRL, 32'h0);
    t0 = cyc;
    chk("osc", osc_en, 1'b1);
    @(negedge mclk);
    x0 = xclk;
    @(negedge mclk);
    chk("xclk", xclk, !x0);
    @(posedge mclk);
    rdc(OFS_STAB_STAT, 32'h0);
    n = 0;
    do begin
      xfer(1'b0, OFS_STAB_STAT, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 200);
    chk("stab", rd[0] && cyc - t0 >= STAB_BASE_CYC - 4, 1'b1);
    xfer(1'b1, OFS_MCLK_MODE, 32'h5);
    rdc(OFS_MCLK_MODE, 32'h7);
    chk("route", {rt.main_hs, rt.periph_hs}, 2'h3);
  endtask

  task t_div;
    for (int k = 0; k < 5; k++) begin
      xfer(1'b1, OFS_PROC_CTRL, k);
      rdc(OFS_PROC_CTRL, k);
      n = 0;
      m = 0;
      repeat (32) begin
        @(negedge mclk);
        n += (rt.cpu_div_en == 5'h01 << k);
        m += (rt.cpu_div_en != 5'h00);
      end
      chk("div_hits", n, 32 >> k);
      chk("div_any", m, 32 >> k);
      @(posedge mclk);
    end
    xfer(1'b1, OFS_PROC_CTRL, 32'h5);
    rdc(OFS_PROC_CTRL, 32'h4);
    xfer(1'b1, OFS_PROC_CTRL, 32'h14);
    rdc(OFS_PROC_CTRL, 32'h34);
    chk("cpu_en", rt.cpu_en, 1'b0);
  endtask

  task t_stop;
    xfer(1'b1, OFS_STAB_SEL, 32'h3);
    rdc(OFS_STAB_SEL, 32'h3);
    xfer(1'b1, OFS_STOP_CMD, 32'h1);
    chk("stop", {stop_mode, osc_en, ext_en}, 3'h4);
    stp <= 1'b1;
    @(posedge mclk);
    stp <= 1'b0;
    @(posedge mclk);
    chk("stop", stop_mode, 1'b0);
  endtask

  task t_halt;
    rdc(OFS_PROC_CTRL, 32'h34);
    xfer(1'b1, OFS_MOSC_CTRL, 32'h80);
    chk("osc", osc_en, 1'b0);
    @(negedge mclk);
    chk("xclk", xclk, 1'b0);
    @(posedge mclk);
    rdc(OFS_STAB_STAT, 32'h0);
    xfer(1'b1, OFS_OSC_CTRL, 32'h91);
    chk("pins", pin, PIN_EXTCLK);
    xfer(1'b1, OFS_MOSC_CTRL, 32'h0);
    chk("ext", {ext_en, osc_en}, 2'h2);
    xfer(1'b0, 8'h40, 32'h0);
    chk("slverr", er, 1'b1);
    chk("rdata", rd, 32'h0);
  endtask

  // reset in mid-run, gain may change once again
  task t_rerst;
    rst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk("pins", pin, PIN_PORT);
    chk("gain", gain, 1'b0);
    xfer(1'b1, OFS_OSC_CTRL, 32'h1);
    chk("gain", gain, 1'b1);
  endtask

  // stimulus sequence
  initial begin
    {rst_n, psel, penable, pwrite, stp, paddr, pwdata} = '0;
    cyc = 0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset;
    t_gain;
    t_reson;
    t_div;
    t_stop;
    t_halt;
    t_rerst;
    end_of_test;
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    end_of_test;
  end
endmodule

bind hsc_top hsc_chk u_hsc_chk (.MCLK, .RST_N, .STOP_MODE, .PIN_MODE,
  .OSC_ENABLE, .OSC_HIGH_GAIN, .EXT_INPUT_EN, .CLK_ROUTE);
